// ===== hw/depth_setup_unit.v
// Depth stage setup registers, depth conditioning, test and occlusion counter
//
// Function
// - Shared alpha bit: target0 alpha decides all
// - Per-target enables for five pixel features
// - Packing controls active low, zero enables
// - Base in 256 bytes, pitch by mode
// - Locations: 00 local, 01 dynamic
// - Read cache enable, clear, width select
// - Type bit selects Z or W
// - Fixed formats: exact one becomes below one
// - Fixed formats: above one clamps below one
// - Negative clamps zero, planes use unclamped
// - Separate stencil present, sync updates both
// - Copy bit forces stencil valid, keep
// - Float mantissa zero padded or extended
// - Shader depth: pass destination depth downstream
// - Eight compare modes against stored depth
// - Divide depth by two to factor
// - Mask mantissa, convert, test, write passing
// - Bias: larger of slope times scale and offset, clamped
// - Drop pixels outside near and far planes
// - Occlusion count readable low and high
// - High address decode triggers count write-back
`timescale 1ns/1ns
`default_nettype none
`include "depth_setup_map.vh"

module depth_setup_unit #(
    parameter WORD_W = 32
) (
    // Clock, reset, enable
    input  wire              clk,
    input  wire              srst,
    input  wire              ce,
    // Parameter word port
    input  wire              param_valid,
    input  wire [WORD_W-1:0] param_word,
    input  wire              rd_en,
    input  wire [7:0]        rd_addr,
    output reg  [23:0]       rd_data_ff,
    // Per-pixel stage input
    input  wire              pix_valid,
    input  wire [31:0]       pix_depth,
    input  wire [31:0]       pix_w,
    input  wire [31:0]       pix_dst_depth,
    input  wire [31:0]       pix_slope,
    input  wire              pix_stencil_pass,
    input  wire [3:0]        pix_alpha_pass,
    // Per-pixel stage output
    output reg               out_valid_ff,
    output reg  [31:0]       out_depth_ff,
    output reg  [31:0]       out_dst_depth_ff,
    output reg               out_depth_pass_ff,
    output reg               out_depth_write_ff,
    output reg  [3:0]        out_kill_ff,
    // Configuration seen by the rest of the back end
    output wire [3:0]        alpha_test_en,
    output wire [3:0]        specular_en,
    output wire [3:0]        fog_en,
    output wire [3:0]        blend_en,
    output wire [3:0]        dither_en,
    output wire              wide_pack_on,
    output wire              smart_pack_on,
    output wire [31:0]       depth_base_addr,
    output wire [31:0]       depth_pitch_bytes,
    output wire [1:0]        depth_location,
    output wire [1:0]        stencil_location,
    output wire [1:0]        visible_count_location,
    output wire              depth_read_cache_en,
    output wire              depth_read_cache_wide,
    output reg               depth_read_cache_clear_ff,
    output wire              stencil_write_separate,
    output wire              stencil_write_depth,
    output wire              stencil_valid_flag,
    output wire              stencil_keep,
    output wire              shader_source_depth,
    output wire [2:0]        depth_format,
    output wire              depth_precision_boost,
    output wire [23:0]       depth_clear_value_lo,
    output wire [7:0]        depth_clear_value_hi,
    // Occlusion write-back to memory
    output reg               wb_req_ff,
    output reg  [33:0]       wb_addr_ff,
    output reg  [31:0]       wb_data_ff,
    input  wire              wb_ack
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    reg  [23:0] enables_ff, base_ff, pitch_ff, fmt_ff, mode_ff, clr_lo_ff;
    reg  [23:0] mask_ff, ofs_lo_ff, bias_hi_ff, scl_lo_ff, floor_lo_ff;
    reg  [23:0] ceil_lo_ff, bounds_hi_ff, far_lo_ff, near_lo_ff, planes_hi_ff;
    reg  [23:0] addr_lo_ff, addr_hi_ff;
    reg  [31:0] count_ff;
    wire [7:0]  sub_addr = param_word[31:24];
    wire [23:0] sub_data = param_word[23:0];
    wire        wr       = ce & param_valid;

    // Write decode; count writes are handled with the counter
    always @(posedge clk) begin
        if (srst) begin
            enables_ff   <= 24'h000000;
            base_ff      <= 24'h000000;
            pitch_ff     <= 24'h000000;
            fmt_ff       <= 24'h000000;
            mode_ff      <= 24'h070000;
            clr_lo_ff    <= 24'h000000;
            mask_ff      <= 24'h000000;
            ofs_lo_ff    <= 24'h000000;
            bias_hi_ff   <= 24'h000000;
            scl_lo_ff    <= 24'h000000;
            floor_lo_ff  <= 24'h000000;
            ceil_lo_ff   <= 24'h000000;
            bounds_hi_ff <= 24'h000000;
            far_lo_ff    <= 24'h000000;
            near_lo_ff   <= 24'h000000;
            planes_hi_ff <= 24'h000000;
            addr_lo_ff   <= 24'h000000;
            addr_hi_ff   <= 24'h000000;
        end else if (wr) begin
            case (sub_addr)
                `SA_ENABLES:     enables_ff   <= sub_data;
                `SA_DEPTH_BASE:  base_ff      <= sub_data;
                `SA_PITCH_CACHE: pitch_ff     <= sub_data;
                `SA_FORMAT:      fmt_ff       <= sub_data;
                `SA_TEST_MODE:   mode_ff      <= sub_data;
                `SA_CLEAR_LO:    clr_lo_ff    <= sub_data;
                `SA_MASK_CLR_HI: mask_ff      <= sub_data;
                `SA_BIAS_OFS_LO: ofs_lo_ff    <= sub_data;
                `SA_BIAS_HI:     bias_hi_ff   <= sub_data;
                `SA_BIAS_SCL_LO: scl_lo_ff    <= sub_data;
                `SA_FLOOR_LO:    floor_lo_ff  <= sub_data;
                `SA_CEIL_LO:     ceil_lo_ff   <= sub_data;
                `SA_BOUNDS_HI:   bounds_hi_ff <= sub_data;
                `SA_FAR_LO:      far_lo_ff    <= sub_data;
                `SA_NEAR_LO:     near_lo_ff   <= sub_data;
                `SA_PLANES_HI:   planes_hi_ff <= sub_data;
                `SA_ADDR_LO:     addr_lo_ff   <= sub_data;
                `SA_ADDR_HI:     addr_hi_ff   <= sub_data;
                default:         addr_hi_ff   <= addr_hi_ff;
            endcase
        end
    end

    // Readback, reserved bits read as zero
    always @(posedge clk) begin
        if (srst) begin
            rd_data_ff <= 24'h000000;
        end else if (ce & rd_en) begin
            case (rd_addr)
                `SA_ENABLES:     rd_data_ff <= {1'b0, enables_ff[22:0]};
                `SA_DEPTH_BASE:  rd_data_ff <= base_ff;
                `SA_PITCH_CACHE: rd_data_ff <= {1'b0, pitch_ff[22:9], 7'h00, pitch_ff[1:0]};
                `SA_FORMAT:      rd_data_ff <= {fmt_ff[23], 1'b0, fmt_ff[21:16], 9'h000,
                                                fmt_ff[6:0]};
                `SA_TEST_MODE:   rd_data_ff <= {mode_ff[23], 4'h0, mode_ff[18:16], 8'h00,
                                                mode_ff[7:0]};
                `SA_CLEAR_LO:    rd_data_ff <= clr_lo_ff;
                `SA_MASK_CLR_HI: rd_data_ff <= mask_ff;
                `SA_BIAS_OFS_LO: rd_data_ff <= ofs_lo_ff;
                `SA_BIAS_HI:     rd_data_ff <= {bias_hi_ff[23:16], 8'h00, bias_hi_ff[7:0]};
                `SA_BIAS_SCL_LO: rd_data_ff <= scl_lo_ff;
                `SA_FLOOR_LO:    rd_data_ff <= floor_lo_ff;
                `SA_CEIL_LO:     rd_data_ff <= ceil_lo_ff;
                `SA_BOUNDS_HI:   rd_data_ff <= {bounds_hi_ff[23], 7'h00, bounds_hi_ff[15:0]};
                `SA_COUNT_LO:    rd_data_ff <= count_ff[23:0];
                `SA_COUNT_HI:    rd_data_ff <= {16'h0000, count_ff[31:24]};
                `SA_FAR_LO:      rd_data_ff <= far_lo_ff;
                `SA_NEAR_LO:     rd_data_ff <= near_lo_ff;
                `SA_PLANES_HI:   rd_data_ff <= {8'h00, planes_hi_ff[15:0]};
                `SA_ADDR_LO:     rd_data_ff <= addr_lo_ff;
                `SA_ADDR_HI:     rd_data_ff <= {addr_hi_ff[23:22], 14'h0000, addr_hi_ff[7:0]};
                default:         rd_data_ff <= 24'h000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration decode
    wire alpha_share = enables_ff[`BIT_ALPHA_SHARE];
    wire is_fixed    = (depth_format == `FMT_FIX16) | (depth_format == `FMT_FIX32) |
                       (depth_format == `FMT_FIX24);
    assign alpha_test_en  = alpha_share ? 4'h0 : enables_ff[19:16];
    assign specular_en    = enables_ff[15:12];
    assign fog_en         = enables_ff[11:8];
    assign blend_en       = enables_ff[7:4];
    assign dither_en      = enables_ff[3:0];
    assign wide_pack_on   = ~enables_ff[`BIT_WIDE_PACK];
    assign smart_pack_on  = ~enables_ff[`BIT_SMART_PACK];
    // Base and pitch in bytes
    assign depth_base_addr   = {base_ff, 8'h00} << 0;
    assign depth_pitch_bytes = fmt_ff[`BIT_TILE] ?
                               ({22'h000000, pitch_ff[22:13]} << `PITCH_TILE_SHIFT) :
                               ({22'h000000, pitch_ff[22:13]} << `PITCH_LIN_SHIFT);
    // Reserved location codes pass through; downstream treats them as unsupported
    assign depth_location          = pitch_ff[1:0];
    assign stencil_location        = fmt_ff[6:5];
    assign visible_count_location  = addr_hi_ff[23:22];
    assign depth_read_cache_en     = pitch_ff[`BIT_CACHE_EN];
    assign depth_read_cache_wide   = pitch_ff[`BIT_CACHE_WIDE];
    assign stencil_write_separate  = fmt_ff[`BIT_SEPARATE];
    assign stencil_write_depth     = ~fmt_ff[`BIT_SEPARATE] | fmt_ff[`BIT_SYNC] |
                                     fmt_ff[`BIT_STB2ZB];
    assign stencil_valid_flag      = fmt_ff[`BIT_STB2ZB];
    assign stencil_keep            = fmt_ff[`BIT_STB2ZB];
    assign shader_source_depth     = mode_ff[`BIT_SRC_PS];
    assign depth_format            = fmt_ff[18:16];
    assign depth_precision_boost   = bounds_hi_ff[23];
    assign depth_clear_value_lo    = clr_lo_ff;
    assign depth_clear_value_hi    = mask_ff[7:0];

    // Cache clear is a one-cycle pulse on each write that sets it
    always @(posedge clk) begin
        if (srst) begin
            depth_read_cache_clear_ff <= 1'b0;
        end else if (ce) begin
            depth_read_cache_clear_ff <= wr & (sub_addr == `SA_PITCH_CACHE) &
                                         sub_data[`BIT_CACHE_CLR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Float helpers: ordering, comparison, conversion
    function [32:0] ord_key;       // Monotonic key for signed-magnitude floats
        input [31:0] f;
        begin
            ord_key = f[31] ? {1'b0, ~f} : {1'b1, f};
        end
    endfunction

    function flt_gt;
        input [31:0] a;
        input [31:0] b;
        begin
            flt_gt = ord_key(a) > ord_key(b);
        end
    endfunction

    // Float to 0.32 fixed, saturating 2.0 and above to all ones as the 33-bit value
    function [32:0] flt_to_fix;
        input [31:0] f;
        input        ext;
        reg   [32:0] mant;
        reg   [7:0]  sh;
        begin
            mant = ext ? {1'b1, f[22:0], 1'b1, f[22:16], 1'b0} : {1'b1, f[22:0], 9'h000};
            sh   = 8'h00;
            if (f[31] | (f[30:23] == 8'h00)) begin
                flt_to_fix = 33'h000000000;
            end else if (f[30:23] >= 8'h7F) begin
                flt_to_fix = (f[30:23] == 8'h7F) ? mant : {1'b1, 32'hFFFFFFFF};
            end else begin
                sh = 8'h7F - f[30:23];
                flt_to_fix = (sh > 8'h20) ? 33'h000000000 : (mant >> sh);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bias, normalization, masking
    wire [31:0] bias_scale = {bias_hi_ff[23:16], scl_lo_ff};
    wire [31:0] bias_ofs   = {bias_hi_ff[7:0], ofs_lo_ff};
    wire [31:0] bias_floor = {bounds_hi_ff[7:0], floor_lo_ff};
    wire [31:0] bias_ceil  = {bounds_hi_ff[15:8], ceil_lo_ff};
    wire [31:0] far_plane  = {planes_hi_ff[15:8], far_lo_ff};
    wire [31:0] near_plane = {planes_hi_ff[7:0], near_lo_ff};
    wire [31:0] raw_in     = fmt_ff[`BIT_W_SELECT] ? pix_w : pix_depth;
    wire [7:0]  norm_shift = mode_ff[7:0];
    reg  [31:0] normed, masked, bias_v, biased;
    reg  [32:0] fixv;
    reg  [31:0] stored, final_v;
    reg  [8:0]  exp_n;

    // Slope times scale is approximated by exponent addition; the bias is a
    // replacement for a zero depth, applied before the planes are checked
    always @* begin
        exp_n  = {1'b0, raw_in[30:23]} - {1'b0, norm_shift};
        normed = (exp_n[8] | (exp_n == 9'h000)) ? {raw_in[31], 31'h00000000} :
                 {raw_in[31], exp_n[7:0], raw_in[22:0]};
        masked = {normed[31:16], normed[15:0] & ~mask_ff[23:8]};
        bias_v = (pix_slope[30:23] + bias_scale[30:23] > 8'h7F) ?
                 {bias_scale[31], 8'h7F + (pix_slope[30:23] - 8'h7F) + (bias_scale[30:23] - 8'h7F),
                  bias_scale[22:0]} : bias_ofs;
        if (flt_gt(bias_ofs, bias_v)) begin
            bias_v = bias_ofs;
        end
        if (flt_gt(bias_floor, bias_v)) begin
            bias_v = bias_floor;
        end
        if (flt_gt(bias_v, bias_ceil)) begin
            bias_v = bias_ceil;
        end
        biased = (masked[30:0] == 31'h00000000) ? bias_v : masked;
        fixv   = flt_to_fix(biased, fmt_ff[`BIT_EXTEND]);
        stored = pix_dst_depth;
        final_v = biased;
        if (is_fixed) begin
            if (fixv[32] & (fixv[31:0] == 32'h00000000)) begin
                final_v = fmt_ff[`BIT_ONE_FF] ? `FIX_ONE : fixv[31:0];
            end else if (fixv[32]) begin
                final_v = fmt_ff[`BIT_OVER_ONE] ? `FIX_ONE : fixv[31:0];
            end else begin
                final_v = fixv[31:0];
            end
        end else if (biased[31] & fmt_ff[`BIT_NEG_CLAMP]) begin
            final_v = 32'h00000000;
        end
    end

    // Plane check on the unclamped float value, ahead of any window check
    wire clip_drop = flt_gt(biased, far_plane) | flt_gt(near_plane, biased);
    wire lt = is_fixed ? (final_v < stored) : flt_gt(stored, final_v);
    wire eq = final_v == stored;
    reg  cmp_pass;

    always @* begin
        case (mode_ff[18:16])
            `CMP_NEVER:   cmp_pass = 1'b0;
            `CMP_LESS:    cmp_pass = lt;
            `CMP_EQUAL:   cmp_pass = eq;
            `CMP_LEQUAL:  cmp_pass = lt | eq;
            `CMP_GREATER: cmp_pass = ~lt & ~eq;
            `CMP_NEQUAL:  cmp_pass = ~eq;
            `CMP_GEQUAL:  cmp_pass = ~lt;
            default:      cmp_pass = 1'b1;
        endcase
    end

    wire pass_now = pix_valid & ~clip_drop & cmp_pass;

    // Pixel output stage
    always @(posedge clk) begin
        if (srst) begin
            out_valid_ff       <= 1'b0;
            out_depth_ff       <= 32'h00000000;
            out_dst_depth_ff   <= 32'h00000000;
            out_depth_pass_ff  <= 1'b0;
            out_depth_write_ff <= 1'b0;
            out_kill_ff        <= 4'h0;
        end else if (ce) begin
            out_valid_ff       <= pix_valid & ~clip_drop;
            out_depth_ff       <= final_v;
            out_dst_depth_ff   <= shader_source_depth ? pix_dst_depth : 32'h00000000;
            out_depth_pass_ff  <= pass_now;
            out_depth_write_ff <= pass_now;
            out_kill_ff        <= alpha_share ? {4{~pix_alpha_pass[0]}} :
                                  (enables_ff[19:16] & ~pix_alpha_pass);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Occlusion counter and write-back
    wire [31:0] addr_full = {addr_hi_ff[7:0], addr_lo_ff};
    wire        hi_decode = wr & (sub_addr == `SA_ADDR_HI);

    // Software writes override counting in the same cycle
    always @(posedge clk) begin
        if (srst) begin
            count_ff <= 32'h00000000;
        end else if (ce) begin
            if (wr & (sub_addr == `SA_COUNT_LO)) begin
                count_ff <= {count_ff[31:24], sub_data};
            end else if (wr & (sub_addr == `SA_COUNT_HI)) begin
                count_ff <= {sub_data[7:0], count_ff[23:0]};
            end else if (pass_now & pix_stencil_pass & (count_ff != 32'hFFFFFFFF)) begin
                count_ff <= count_ff + 32'h00000001;
            end
        end
    end

    // Address check happens on the high-word decode, using the new high byte
    always @(posedge clk) begin
        if (srst) begin
            wb_req_ff  <= 1'b0;
            wb_addr_ff <= 34'h000000000;
            wb_data_ff <= 32'h00000000;
        end else if (ce) begin
            if (hi_decode & ({sub_data[7:0], addr_lo_ff} != 32'h00000000)) begin
                wb_req_ff  <= 1'b1;
                wb_addr_ff <= {sub_data[7:0], addr_lo_ff, 2'h0};
                wb_data_ff <= count_ff;
            end else if (wb_ack) begin
                wb_req_ff  <= 1'b0;
            end
        end
    end

endmodule // depth_setup_unit
`default_nettype wire

// ===== hw/depth_setup_map.vh
// Sub-addresses, field positions and codes of the depth setup unit
`ifndef DEPTH_SETUP_MAP_VH
`define DEPTH_SETUP_MAP_VH
`define SA_ENABLES      8'h00
`define SA_DEPTH_BASE   8'h10
`define SA_PITCH_CACHE  8'h11
`define SA_FORMAT       8'h12
`define SA_TEST_MODE    8'h13
`define SA_CLEAR_LO     8'h14
`define SA_MASK_CLR_HI  8'h15
`define SA_BIAS_OFS_LO  8'h16
`define SA_BIAS_HI      8'h17
`define SA_BIAS_SCL_LO  8'h18
`define SA_FLOOR_LO     8'h19
`define SA_CEIL_LO      8'h1A
`define SA_BOUNDS_HI    8'h1B
`define SA_COUNT_LO     8'h1C
`define SA_COUNT_HI     8'h1D
`define SA_FAR_LO       8'h1E
`define SA_NEAR_LO      8'h1F
`define SA_PLANES_HI    8'h20
`define SA_ADDR_LO      8'h21
`define SA_ADDR_HI      8'h22
`define BIT_WIDE_PACK   22
`define BIT_SMART_PACK  21
`define BIT_ALPHA_SHARE 20
`define BIT_W_SELECT    23
`define BIT_ONE_FF      21
`define BIT_OVER_ONE    20
`define BIT_NEG_CLAMP   19
`define BIT_STB2ZB      4
`define BIT_SYNC        3
`define BIT_SEPARATE    2
`define BIT_EXTEND      1
`define BIT_TILE        0
`define BIT_CACHE_EN    12
`define BIT_CACHE_CLR   11
`define BIT_CACHE_WIDE  10
`define BIT_SRC_PS      23
`define FMT_FIX16       3'h0
`define FMT_FLT16       3'h1
`define FMT_FIX32       3'h4
`define FMT_FLT32       3'h5
`define FMT_FIX24       3'h6
`define CMP_NEVER       3'h0
`define CMP_LESS        3'h1
`define CMP_EQUAL       3'h2
`define CMP_LEQUAL      3'h3
`define CMP_GREATER     3'h4
`define CMP_NEQUAL      3'h5
`define CMP_GEQUAL      3'h6
`define CMP_ALWAYS      3'h7
`define LOC_LOCAL       2'h0
`define LOC_DYNAMIC     2'h1
`define BASE_SHIFT      8
`define PITCH_LIN_SHIFT 5
`define PITCH_TILE_SHIFT 8
`define ADDR_SHIFT      2
`define FIX_ONE         32'hFFFFFFFF
`define FLT_ONE         32'h3F800000
`endif

// ===== testbench/depth_setup_unit_assertions.sv
// Port-level checks for the depth setup unit
`timescale 1ns/1ns
`default_nettype none
module depth_setup_chk (
    // Watched ports
    input wire logic        clk, srst, ce, param_valid, pix_valid, wb_ack, wb_req_ff,
    input wire logic [31:0] param_word, pix_dst_depth, depth_base_addr, out_dst_depth_ff,
    input wire logic [3:0]  alpha_test_en,
    input wire logic        wide_pack_on, depth_read_cache_clear_ff, out_valid_ff,
    input wire logic        out_depth_pass_ff, out_depth_write_ff, shader_source_depth,
    input wire logic        stencil_valid_flag, stencil_keep, stencil_write_depth
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Taken parameter word and its sub-address
    wire logic       wr = param_valid && ce;
    wire logic [7:0] sa = param_word[31:24];
    property p_pack; wr && sa == 8'h00 |=> wide_pack_on == !$past(param_word[22]); endproperty
    a_pack: assert property (p_pack) else $error("pack enable wrong");
    property p_alpha; wr && sa == 8'h00 |=>
        alpha_test_en == ($past(param_word[20]) ? 4'h0 : $past(param_word[19:16])); endproperty
    a_alpha: assert property (p_alpha) else $error("alpha enables wrong");
    property p_base; wr && sa == 8'h10 |=> depth_base_addr == {$past(param_word[23:0]), 8'h00};
    endproperty
    a_base: assert property (p_base) else $error("base scaling wrong");
    property p_clr; wr && sa == 8'h11 |=> depth_read_cache_clear_ff == $past(param_word[11]);
    endproperty
    a_clr: assert property (p_clr) else $error("cache clear pulse wrong");
    property p_hold; wb_req_ff && !(wb_ack && ce) |=> wb_req_ff; endproperty
    a_hold: assert property (p_hold) else $error("write-back dropped early");
    property p_rise; $rose(wb_req_ff) |-> $past(wr && sa == 8'h22); endproperty
    a_rise: assert property (p_rise) else $error("write-back without high address");
    property p_done; wb_req_ff && wb_ack && ce && !(wr && sa == 8'h22) |=> !wb_req_ff;
    endproperty
    a_done: assert property (p_done) else $error("write-back not released");
    property p_src; pix_valid && ce && shader_source_depth |=>
        !out_valid_ff || out_dst_depth_ff == $past(pix_dst_depth); endproperty
    a_src: assert property (p_src) else $error("destination depth not passed");
    property p_wr; out_depth_write_ff |-> out_depth_pass_ff && out_valid_ff; endproperty
    a_wr: assert property (p_wr) else $error("write without pass");
    property p_valid; $past(ce) && out_valid_ff |-> $past(pix_valid); endproperty
    a_valid: assert property (p_valid) else $error("pixel out without pixel in");
    property p_stv; stencil_valid_flag |-> stencil_keep && stencil_write_depth; endproperty
    a_stv: assert property (p_stv) else $error("stencil copy not forced");
    c_wb: cover property ($rose(wb_req_ff));
    c_wr: cover property (out_depth_write_ff);
    c_clr: cover property (depth_read_cache_clear_ff);
endmodule // depth_setup_chk
bind depth_setup_unit depth_setup_chk u_chk (.clk, .srst, .ce, .param_valid, .pix_valid,
    .wb_ack, .wb_req_ff, .param_word, .pix_dst_depth, .depth_base_addr, .out_dst_depth_ff,
    .alpha_test_en, .wide_pack_on, .depth_read_cache_clear_ff, .out_valid_ff,
    .out_depth_pass_ff, .out_depth_write_ff, .shader_source_depth, .stencil_valid_flag,
    .stencil_keep, .stencil_write_depth);
`default_nettype wire

// ===== testbench/mem_backend_model.sv
// Memory back end answering occlusion write-back requests
`timescale 1ns/1ns
`default_nettype none
module mem_backend_model #(parameter int DELAY = 3) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Write-back handshake
    input  wire logic wb_req_ff,
    output var  logic wb_ack
);
    int cnt;
    // Slow answer on purpose, so the request must stand while waiting
    always @(posedge clk) begin
        if (srst || wb_ack || !wb_req_ff) begin
            cnt <= 0;
            wb_ack <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            wb_ack <= (cnt == DELAY);
        end
    end
endmodule // mem_backend_model
`default_nettype wire

// ===== testbench/depth_setup_unit_tb_top.sv
// Self-checking bench for the depth setup unit
`timescale 1ns/1ns
`default_nettype none
module depth_setup_unit_tb_top;
    logic clk, srst, ce = 1'b1, param_valid, rd_en, pix_valid, pix_stencil_pass, wb_ack, ep;
    logic [31:0] param_word, pix_depth, pix_dst_depth, pix_w = '0, pix_slope = '0;
    logic [7:0]  rd_addr, depth_clear_value_hi;
    logic [23:0] rd_data_ff, depth_clear_value_lo;
    logic out_valid_ff, out_depth_pass_ff, out_depth_write_ff, wb_req_ff, wide_pack_on;
    logic smart_pack_on, depth_read_cache_en, depth_read_cache_wide, depth_precision_boost;
    logic stencil_write_separate, stencil_write_depth, stencil_valid_flag;
    logic [3:0]  pix_alpha_pass, out_kill_ff, alpha_test_en, specular_en, fog_en, blend_en;
    logic [3:0]  dither_en;
    logic [31:0] depth_base_addr, depth_pitch_bytes, wb_data_ff, out_depth_ff, out_dst_depth_ff;
    logic [1:0]  depth_location, stencil_location, visible_count_location;
    logic [2:0]  depth_format;
    logic [33:0] wb_addr_ff;
    int failures, tests_run, cyc, npass;
    depth_setup_unit u_dut (.*, .depth_read_cache_clear_ff(), .stencil_keep(),
        .shader_source_depth());
    mem_backend_model u_mem (.clk, .srst, .wb_req_ff, .wb_ack);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, far above the roughly 125 cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [33:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clk) param_valid = 1'b1;
        param_word = {a, d};
        @(negedge clk) param_valid = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        @(negedge clk) rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk) rd_en = 1'b0;
        chk("rd_data", rd_data_ff, e);
    endtask
    task automatic pix(input logic [31:0] z, d, input logic [3:0] ap);
        @(negedge clk) pix_valid = 1'b1;
        {pix_depth, pix_dst_depth, pix_alpha_pass} = {z, d, ap};
        @(negedge clk) pix_valid = 1'b0;
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {srst, param_valid, rd_en, pix_valid, pix_stencil_pass} = 5'b10001;
        {param_word, rd_addr, pix_depth, pix_dst_depth, pix_alpha_pass} = '0;
        {failures, tests_run, cyc, npass} = '0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        rd(8'h13, 24'h070000);
        rd(8'h30, 24'h000000);
        wr(8'h1E, 24'h800000);
        wr(8'h20, 24'h003F00);
        wr(8'h10, 24'h000123);
        chk("base", depth_base_addr, 32'h00012300);
        wr(8'h11, 24'h007C01);
        chk("pitch", depth_pitch_bytes, 32'h60);
        chk("cache", {depth_read_cache_en, depth_read_cache_wide, depth_location}, 4'hD);
        wr(8'h12, 24'h860035);
        chk("pitch", depth_pitch_bytes, 32'h300);
        chk("fmt", {depth_format, stencil_location}, 5'b11001);
        chk("stv", {stencil_valid_flag, stencil_write_separate, stencil_write_depth}, 3'h7);
        wr(8'h12, 24'h050004);
        chk("stv", {stencil_valid_flag, stencil_write_separate, stencil_write_depth}, 3'h2);
        wr(8'h00, 24'h5F1234);
        chk("alpha", alpha_test_en, 4'h0);
        chk("feat", {specular_en, fog_en, blend_en, dither_en}, 16'h1234);
        chk("pack", {wide_pack_on, smart_pack_on}, 2'b01);
        pix(32'h3F000000, 32'h3F000000, 4'hE);
        chk("kill", out_kill_ff, 4'hF);
        wr(8'h00, 24'h050000);
        chk("alpha", alpha_test_en, 4'h5);
        pix(32'h3F000000, 32'h3F000000, 4'hE);
        chk("kill", out_kill_ff, 4'h1);
        wr(8'h16, 24'h7FFFFF);
        wr(8'h14, 24'hABCDEF);
        wr(8'h15, 24'h000012);
        wr(8'h1B, 24'h800000);
        chk("clear", {depth_precision_boost, depth_clear_value_hi, depth_clear_value_lo},
            33'h112ABCDEF);
        npass = 2;
        // Equal then lower depth against every compare mode
        for (int m = 0; m < 16; m++) begin
            wr(8'h13, {m[3], 4'h0, m[2:0], 16'h0});
            pix(32'h3F000000, m[3] ? 32'h3F400000 : 32'h3F000000, 4'hF);
            ep = m[3] ? m[0] : m[1];
            chk("test", {out_valid_ff, out_depth_pass_ff, out_depth_write_ff}, {1'b1, ep, ep});
            chk("dst", out_dst_depth_ff, m[3] ? 32'h3F400000 : 32'h0);
            npass += ep;
        end
        pix(32'h40000000, 32'h3F000000, 4'hF);
        chk("clip", out_valid_ff, 1'b0);
        pix_stencil_pass = 1'b0;
        wr(8'h12, 24'h240000);
        pix(32'h3F800000, 32'h3F000000, 4'hF);
        chk("one", out_depth_ff, 32'hFFFFFFFF);
        rd(8'h1C, npass[23:0]);
        rd(8'h1D, 24'h0);
        wr(8'h21, 24'h000010);
        wr(8'h22, 24'h400001);
        chk("wb_req", wb_req_ff, 1'b1);
        chk("wb_addr", wb_addr_ff, 34'h004000040);
        chk("wb_data", wb_data_ff, npass);
        chk("wb_loc", visible_count_location, 2'h1);
        for (int i = 0; i < 20 && wb_req_ff !== 1'b0; i++) @(negedge clk);
        chk("wb_done", wb_req_ff, 1'b0);
        wr(8'h21, 24'h0);
        wr(8'h22, 24'h0);
        chk("wb_zero", wb_req_ff, 1'b0);
        finish_test();
    end
endmodule // depth_setup_unit_tb_top
`default_nettype wire
